// ---- pkg/rxsw_pkg.sv ----
// constants and field layout for the receive status word builder
package rxsw_pkg;
  // status word field positions
  localparam int unsigned BIT_FILTER_FAIL = 30;
  localparam int unsigned LEN_MSB = 29;
  localparam int unsigned LEN_LSB = 16;
  localparam int unsigned LEN_W = 14;
  localparam int unsigned BIT_ERR_SUM = 15;
  localparam int unsigned BIT_BCAST = 13;
  localparam int unsigned BIT_LEN_MISMATCH = 12;
  localparam int unsigned BIT_RUNT = 11;
  localparam int unsigned BIT_MCAST = 10;
  localparam int unsigned BIT_TOO_LONG = 7;
  localparam int unsigned BIT_LATE_COL = 6;
  localparam int unsigned BIT_FRAME_TYPE = 5;
  localparam int unsigned BIT_WATCHDOG = 4;
  localparam int unsigned BIT_MII_ERR = 3;
  localparam int unsigned BIT_DRIBBLE = 2;
  localparam int unsigned BIT_CRC_ERR = 1;
  // frame size thresholds in bytes, the type field threshold and the 10 Mbps minimum dribble bit count
  localparam logic [13:0] COLL_WINDOW_BYTES = 14'd64;
  localparam logic [13:0] MAX_FRAME_BYTES = 14'd1518;
  localparam logic [13:0] TYPE_FIELD_END_BYTES = 14'd14;
  localparam logic [13:0] WATCHDOG_BYTES = 14'd2048;
  localparam logic [15:0] TYPE_THRESHOLD = 16'd1500;
  localparam logic [2:0] MIN_DRIBBLE_10M = 3'd3;
  // status fifo depth
  localparam int unsigned SFIFO_DEPTH = 4;
  localparam int unsigned SFIFO_AW = 2;
  // register map (byte addresses)
  localparam logic [3:0] REG_CTRL = 4'h0;
  localparam logic [3:0] REG_STATUS = 4'h4;
  localparam logic [3:0] REG_RX_STATUS = 4'h8;
  localparam logic [3:0] REG_FIFO_INFO = 4'hC;
  // control and status register field positions, and bus response codes
  localparam int unsigned CTRL_PASS_BAD = 0;
  localparam int unsigned CTRL_SPEED_10M = 1;
  localparam int unsigned STAT_RX_ERR = 0;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : rxsw_pkg

// ---- hw/rxsw_encode.sv ----
// combinational encoder from frame observations to the status word
`timescale 1ns/1ps
module rxsw_encode (
  // frame observations
  input wire logic [13:0] frame_bytes,
  input wire logic [15:0] len_type,
  input wire logic filter_fail,
  input wire logic dest_bcast,
  input wire logic dest_mcast,
  input wire logic late_col,
  input wire logic fcs_bad,
  input wire logic rx_er_seen,
  input wire logic [2:0] extra_bits,
  input wire logic speed_10m,
  // encoded word
  output logic [31:0] word
);
  logic runt;
  logic too_long;
  logic wdog;
  logic ftype;
  logic len_mis;
  logic dribble;
  logic crc_err;
  logic err_sum;

  // size classes
  assign runt = frame_bytes < rxsw_pkg::COLL_WINDOW_BYTES;
  assign too_long = frame_bytes > rxsw_pkg::MAX_FRAME_BYTES;
  assign wdog = frame_bytes > rxsw_pkg::WATCHDOG_BYTES;
  // type field only exists once 14 bytes arrived
  assign ftype = (len_type > rxsw_pkg::TYPE_THRESHOLD) &&
                 (frame_bytes >= rxsw_pkg::TYPE_FIELD_END_BYTES);
  // length field only checked for length-encoded frames
  assign len_mis = !ftype && (frame_bytes >= rxsw_pkg::TYPE_FIELD_END_BYTES) &&
                   ({2'b00, frame_bytes} != len_type);
  // at 10 Mbps a few stray bits are noise, not dribble
  assign dribble = !late_col && (extra_bits != 3'd0) &&
                   (!speed_10m || extra_bits >= rxsw_pkg::MIN_DRIBBLE_10M);
  assign crc_err = fcs_bad || rx_er_seen;
  assign err_sum = runt || too_long || late_col || crc_err;

  // assemble; all unnamed positions stay zero
  always_comb begin
    word = 32'h0000_0000;
    word[rxsw_pkg::BIT_FILTER_FAIL] = filter_fail;
    word[rxsw_pkg::LEN_MSB:rxsw_pkg::LEN_LSB] = frame_bytes;
    word[rxsw_pkg::BIT_ERR_SUM] = err_sum;
    word[rxsw_pkg::BIT_BCAST] = dest_bcast;
    word[rxsw_pkg::BIT_LEN_MISMATCH] = len_mis;
    word[rxsw_pkg::BIT_RUNT] = runt;
    word[rxsw_pkg::BIT_MCAST] = dest_mcast;
    word[rxsw_pkg::BIT_TOO_LONG] = too_long;
    word[rxsw_pkg::BIT_LATE_COL] = late_col;
    word[rxsw_pkg::BIT_FRAME_TYPE] = ftype;
    word[rxsw_pkg::BIT_WATCHDOG] = wdog;
    word[rxsw_pkg::BIT_MII_ERR] = rx_er_seen;
    word[rxsw_pkg::BIT_DRIBBLE] = dribble;
    word[rxsw_pkg::BIT_CRC_ERR] = crc_err;
  end
endmodule : rxsw_encode

// ---- hw/rxsw_fifo.sv ----
// small flip-flop fifo holding queued status words
`timescale 1ns/1ps
module rxsw_fifo (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic flush,
  // write side
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [31:0] wr_data,
  // read side
  output logic rd_valid,
  input wire logic rd_ready,
  output logic [31:0] rd_data,
  output logic [rxsw_pkg::SFIFO_AW:0] count
);
  logic [31:0] mem_q [rxsw_pkg::SFIFO_DEPTH];
  logic [rxsw_pkg::SFIFO_AW-1:0] wp_q;
  logic [rxsw_pkg::SFIFO_AW-1:0] rp_q;
  logic [rxsw_pkg::SFIFO_AW:0] cnt_q;
  logic push;
  logic pop;

  assign wr_ready = cnt_q != rxsw_pkg::SFIFO_DEPTH[rxsw_pkg::SFIFO_AW:0];
  assign rd_valid = cnt_q != '0;
  assign push = wr_valid && wr_ready;
  assign pop = rd_valid && rd_ready;
  assign rd_data = mem_q[rp_q];
  assign count = cnt_q;

  // pointers and occupancy
  always_ff @(posedge aclk) begin
    if (!aresetn || flush) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      if (push && !pop) cnt_q <= cnt_q + 1'b1;
      else if (pop && !push) cnt_q <= cnt_q - 1'b1;
    end
  end

  // storage needs no reset; reads are gated by rd_valid
  always_ff @(posedge aclk) begin
    if (push) mem_q[wp_q] <= wr_data;
  end
endmodule : rxsw_fifo

// ---- hw/rxsw_top.sv ----
// receive status word builder with status fifo and axi4-lite registers
//
// The AXI4-Lite slave port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module rxsw_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frame end report from the mac interface layer
  input wire logic frame_done,
  input wire logic [13:0] frame_bytes,
  input wire logic [15:0] len_type,
  input wire logic filter_fail,
  input wire logic dest_bcast,
  input wire logic dest_mcast,
  input wire logic late_col,
  input wire logic fcs_bad,
  input wire logic rx_er_seen,
  input wire logic [2:0] extra_bits,
  // frame delivery decision toward the data fifo
  output logic frame_deliver,
  output logic frame_drop,
  // receiver error flag level
  output logic receiver_error_flag,
  // axi4-lite write address
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  // host mac control register bits and the receiver error status bit
  logic pass_bad_frames_q;
  logic speed_10m_q;
  logic receiver_error_q;
  logic receiver_error_d;

  // encoded status and queueing decision
  logic [31:0] status_word;
  logic is_runt;
  logic queue_req;
  logic fifo_wr_ready;
  logic fifo_rd_valid;
  logic fifo_pop;
  logic [31:0] fifo_rd_data;
  logic [rxsw_pkg::SFIFO_AW:0] fifo_count;
  logic overrun;
  logic underrun;

  // write channel capture
  logic aw_held_q;
  logic [3:0] aw_addr_q;
  logic w_held_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic do_write;
  logic [3:0] wr_addr;
  logic wr_hit_ctrl;
  logic wr_hit_stat;
  logic wr_mapped;

  // read channel
  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic do_read;
  logic rd_mapped;
  logic [31:0] rd_mux;
  logic [31:0] ctrl_view;
  logic [31:0] stat_view;
  logic [31:0] info_view;

  // status word dribble bit depends on the 10 Mbps speed bit of the control register
  rxsw_encode u_encode (
    .frame_bytes(frame_bytes),
    .len_type(len_type),
    .filter_fail(filter_fail),
    .dest_bcast(dest_bcast),
    .dest_mcast(dest_mcast),
    .late_col(late_col),
    .fcs_bad(fcs_bad),
    .rx_er_seen(rx_er_seen),
    .extra_bits(extra_bits),
    .speed_10m(speed_10m_q),
    .word(status_word)
  );

  // runt frames are dropped unless software asks for bad frames
  assign is_runt = status_word[rxsw_pkg::BIT_RUNT];
  assign queue_req = frame_done && (!is_runt || pass_bad_frames_q);
  assign frame_deliver = queue_req;
  assign frame_drop = frame_done && !queue_req;

  // a full fifo loses the word but never stalls the receiver
  assign overrun = queue_req && !fifo_wr_ready;

  rxsw_fifo u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .flush(1'b0),
    .wr_valid(queue_req),
    .wr_ready(fifo_wr_ready),
    .wr_data(status_word),
    .rd_valid(fifo_rd_valid),
    .rd_ready(fifo_pop),
    .rd_data(fifo_rd_data),
    .count(fifo_count)
  );

  // write path: address and data may arrive in either order
  assign s_axi_awready = !aw_held_q && !bvalid_q;
  assign s_axi_wready = !w_held_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign do_write = aw_held_q && w_held_q && !bvalid_q;
  assign wr_addr = aw_addr_q;
  assign wr_hit_ctrl = wr_addr == rxsw_pkg::REG_CTRL;
  assign wr_hit_stat = wr_addr == rxsw_pkg::REG_STATUS;
  // status fifo port and info are read-only
  assign wr_mapped = wr_hit_ctrl || wr_hit_stat;

  // receiver error: set beats the write-one-to-clear
  assign receiver_error_d = overrun || underrun ||
      (receiver_error_q && !(do_write && wr_hit_stat && w_strb_q[0] &&
       w_data_q[rxsw_pkg::STAT_RX_ERR]));
  assign receiver_error_flag = receiver_error_q;

  // capture write address and data
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= 4'h0;
      w_held_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        aw_addr_q <= {s_axi_awaddr[3:2], 2'b00};
      end else if (do_write) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end else if (do_write) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // write response and control register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= rxsw_pkg::RESP_OKAY;
      pass_bad_frames_q <= 1'b0;
      speed_10m_q <= 1'b0;
    end else begin
      if (do_write) begin
        bvalid_q <= 1'b1;
        bresp_q <= wr_mapped ? rxsw_pkg::RESP_OKAY : rxsw_pkg::RESP_SLVERR;
        if (wr_hit_ctrl && w_strb_q[0]) begin
          pass_bad_frames_q <= w_data_q[rxsw_pkg::CTRL_PASS_BAD];
          speed_10m_q <= w_data_q[rxsw_pkg::CTRL_SPEED_10M];
        end
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) receiver_error_q <= 1'b0;
    else receiver_error_q <= receiver_error_d;
  end

  // read path: one read under way, answer one cycle after address
  assign s_axi_arready = !rvalid_q;
  assign do_read = s_axi_arvalid && !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign ctrl_view = {30'h0000_0000, speed_10m_q, pass_bad_frames_q};
  assign stat_view = {31'h0000_0000, receiver_error_q};
  assign info_view = {29'h0000_0000, fifo_count};
  // reading the status port pops one word; reading it empty is an underrun
  assign fifo_pop = do_read && (s_axi_araddr[3:2] == rxsw_pkg::REG_RX_STATUS[3:2]) &&
                    fifo_rd_valid;
  assign underrun = do_read && (s_axi_araddr[3:2] == rxsw_pkg::REG_RX_STATUS[3:2]) &&
                    !fifo_rd_valid;
  assign rd_mapped = 1'b1;
  assign rd_mux = (s_axi_araddr[3:2] == rxsw_pkg::REG_CTRL[3:2]) ? ctrl_view :
                  (s_axi_araddr[3:2] == rxsw_pkg::REG_STATUS[3:2]) ? stat_view :
                  (s_axi_araddr[3:2] == rxsw_pkg::REG_RX_STATUS[3:2]) ?
                  (fifo_rd_valid ? fifo_rd_data : 32'h0000_0000) : info_view;

  // read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= rxsw_pkg::RESP_OKAY;
    end else begin
      if (do_read) begin
        rvalid_q <= 1'b1;
        rdata_q <= rd_mux;
        rresp_q <= rd_mapped ? rxsw_pkg::RESP_OKAY : rxsw_pkg::RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
    end
  end
endmodule : rxsw_top

// ---- testbench/rxsw_properties.sv ----
// checker watching the status word builder ports
`timescale 1ns/1ps
module rxsw_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // frame port
  input wire logic frame_done,
  input wire logic [13:0] frame_bytes,
  input wire logic frame_deliver,
  input wire logic frame_drop,
  // register bus
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // both write channels taken at one edge, and a read address taken
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_WR_ANSWER: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write answer missing");
  AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read answer missing");
  AST_RD_ONE: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer repeated");
  AST_WR_ONE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer repeated");
  AST_AR_BLOCK: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answering");
  AST_AW_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answering");
  AST_DELIVER_ONE: assert property (frame_done |-> frame_deliver != frame_drop)
    else $error("frame neither or both delivered and dropped");
  AST_NO_DELIVER: assert property (!frame_done |-> !frame_deliver && !frame_drop)
    else $error("delivery without frame");
  AST_BIG_DELIVER: assert property (frame_done && frame_bytes >= 14'h40 |-> frame_deliver)
    else $error("full size frame dropped");
  AST_RESV_ZERO: assert property (s_axi_rvalid |-> s_axi_rdata[31] == 1'b0 &&
    s_axi_rdata[14] == 1'b0 && s_axi_rdata[9:8] == 2'h0) else $error("reserved bit set");
endmodule : rxsw_checker

bind rxsw_top rxsw_checker chk (.*);

// ---- testbench/rxsw_host_model.sv ----
// host model driving the register bus of the block
`timescale 1ns/1ps
module rxsw_host_model (
  // clock
  input wire logic aclk,
  // write channels
  output logic [3:0] s_axi_awaddr,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  // read channels
  output logic [3:0] s_axi_araddr,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  // answer readies stay high: this host never stalls a response
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid} = '0;
    {s_axi_araddr, s_axi_arvalid} = '0;
    s_axi_wstrb = 4'hF;
    s_axi_bready = 1'b1;
    s_axi_rready = 1'b1;
  end
  // crc flag is meaningless on runt, late collision and watchdog frames
  function automatic logic pkt_ok(input logic [31:0] w);
    return !w[1] || w[11] || w[6] || w[4];
  endfunction : pkt_ok
  // each valid drops only at the edge that takes it
  task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw;
    logic w;
    aw = 1'b1;
    w = 1'b1;
    r = 2'h3;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // no cycle limit here: only the bench watchdog ends a hung wait
    forever begin
      @(posedge aclk);
      if (!aw && !w && s_axi_bvalid) begin
        r = s_axi_bresp;
        break;
      end
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    logic ar;
    ar = 1'b1;
    d = '1;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    forever begin
      @(posedge aclk);
      if (!ar && s_axi_rvalid) begin
        d = s_axi_rdata;
        break;
      end
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
  endtask : rd
endmodule : rxsw_host_model

// ---- testbench/tb_rx_status_word_builder.sv ----
// self-checking bench for the status word builder
`timescale 1ns/1ps
module tb_rx_status_word_builder;
  logic aclk, aresetn, frame_done, filter_fail, dest_bcast, dest_mcast, late_col;
  logic fcs_bad, rx_er_seen, frame_deliver, frame_drop, receiver_error_flag;
  logic [13:0] frame_bytes;
  logic [15:0] len_type;
  logic [2:0] extra_bits;
  logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp, ctl;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  int error_cnt = 0;
  int tests_run = 0;
  logic [31:0] seed = 32'h4A;
  logic [31:0] q[$];
  logic [13:0] sz [8] = '{14'hD, 14'hE, 14'h3F, 14'h40, 14'h5EE, 14'h5EF, 14'h800, 14'h801};
  rxsw_top dut (.*);
  rxsw_host_model host (.*);
  // 50 MHz clock
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // expected status word from the frame inputs now on the port
  function automatic logic [31:0] exp_word(input logic sp);
    logic [31:0] w;
    w = 32'h0;
    w[30] = filter_fail;
    w[29:16] = frame_bytes;
    w[13] = dest_bcast;
    w[12] = len_type <= 16'h5DC && frame_bytes >= 14'hE && len_type != {2'h0, frame_bytes};
    w[11] = frame_bytes < 14'h40;
    w[10] = dest_mcast;
    w[7] = frame_bytes > 14'h5EE;
    w[6] = late_col;
    w[5] = len_type > 16'h5DC && frame_bytes >= 14'hE;
    w[4] = frame_bytes > 14'h800;
    w[3] = rx_er_seen;
    w[2] = extra_bits != 3'h0 && (!sp || extra_bits >= 3'h3) && !late_col;
    w[1] = fcs_bad || rx_er_seen;
    w[15] = w[11] || w[7] || w[6] || w[1];
    return w;
  endfunction : exp_word
  // one end-of-frame report; a full fifo loses the word
  task automatic frame(input logic [31:0] r, input logic [13:0] b, input logic [15:0] l);
    logic d;
    frame_done <= 1'b1;
    frame_bytes <= b;
    len_type <= l;
    {filter_fail, dest_bcast, dest_mcast, late_col, fcs_bad, rx_er_seen} <= r[5:0];
    extra_bits <= r[8:6];
    #1;
    d = frame_bytes >= 14'h40 || ctl[0];
    check({31'h0, frame_deliver}, {31'h0, d});
    check({31'h0, frame_drop}, {31'h0, !d});
    if (d && q.size() < 4) q.push_back(exp_word(ctl[1]));
    @(posedge aclk);
    frame_done <= 1'b0;
    @(posedge aclk);
  endtask : frame
  task automatic wrap_up();
    $display("tests %0d errors %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : wrap_up
  // hang guard, far beyond the expected run length
  initial begin
    #200000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    {aresetn, frame_done, frame_bytes, len_type, extra_bits, ctl} = '0;
    {filter_fail, dest_bcast, dest_mcast, late_col, fcs_bad, rx_er_seen} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    host.wr(4'h0, 32'h3, resp);
    host.rd(4'h0, rd);
    check(rd, 32'h3);
    check({30'h0, s_axi_rresp}, 32'h0);
    host.wr(4'hC, 32'h1, resp);
    check({30'h0, resp}, 32'h2);
    $display("test registers done");
    // random frames with corner sizes first, each read back at once
    for (int i = 0; i < 40; i++) begin
      logic [31:0] r;
      logic [13:0] b;
      r = rnd();
      ctl = r[31:30];
      b = i < 8 ? sz[i] : {1'b0, r[24:12]};
      host.wr(4'h0, {30'h0, ctl}, resp);
      frame(r, b, r[10] ? {2'h0, b} : (r[11] ? 16'h5DC : 16'h5DD));
      host.rd(4'hC, rd);
      check(rd, q.size());
      if (q.size() != 0) begin
        host.rd(4'h8, rd);
        check(rd, q.pop_front());
      end
    end
    $display("test frames done");
    // five frames into four places: flag raised, reception goes on
    ctl = 2'h1;
    host.wr(4'h0, 32'h1, resp);
    for (int i = 0; i < 5; i++) frame(rnd(), 14'h5EF, 16'h800);
    check({31'h0, receiver_error_flag}, 32'h1);
    host.wr(4'h4, 32'h1, resp);
    host.rd(4'h4, rd);
    check(rd, 32'h0);
    while (q.size() != 0) begin
      host.rd(4'h8, rd);
      check(rd, q.pop_front());
    end
    host.rd(4'h8, rd);
    check(rd, 32'h0);
    check({31'h0, receiver_error_flag}, 32'h1);
    $display("test overrun done");
    wrap_up();
  end
endmodule : tb_rx_status_word_builder
